// ===== common/hss_pkg.sv
/*
 * Package for the homing and speed select block: register map, field
 * widths, reset values, encodings and bus carrier types.
 * Assumes a 32-bit classic Wishbone slave with word-aligned registers.
 */
package hss_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_POS_SPD1     = 8'h00;
	localparam logic [7:0] OFS_POS_SPD2     = 8'h04;
	localparam logic [7:0] OFS_POS_SPD3     = 8'h08;
	localparam logic [7:0] OFS_POS_SPD4     = 8'h0C;
	localparam logic [7:0] OFS_HOME_SPD     = 8'h10;
	localparam logic [7:0] OFS_CREEP_SPD    = 8'h14;
	localparam logic [7:0] OFS_MODE_CFG     = 8'h18;
	localparam logic [7:0] OFS_REV_AMT      = 8'h1C;
	localparam logic [7:0] OFS_SHIFT_AMT    = 8'h20;
	localparam logic [7:0] OFS_HOME_COORD   = 8'h24;
	localparam logic [7:0] OFS_DET_RANGE    = 8'h28;
	localparam logic [7:0] OFS_OT_DECEL     = 8'h2C;
	localparam logic [7:0] OFS_STOP_TIME    = 8'h30;
	localparam logic [7:0] OFS_STOP_TRQ     = 8'h34;
	localparam logic [7:0] OFS_ACT_MODE     = 8'h38;
	localparam logic [7:0] OFS_STATUS       = 8'h3C;
	localparam logic [7:0] OFS_CUR_POS      = 8'h40;

	// Speeds held in units of 0.01 r/min
	localparam logic [31:0] RST_POS_SPD1    = 32'h0000_03E8; // 10.00
	localparam logic [31:0] RST_POS_SPD2    = 32'h0000_1388; // 50.00
	localparam logic [31:0] RST_POS_SPD3    = 32'h0000_2710; // 100.00
	localparam logic [31:0] RST_POS_SPD4    = 32'h0000_C350; // 500.00
	localparam logic [31:0] RST_HOME_SPD    = 32'h0000_C350; // 500.00
	localparam logic [31:0] RST_CREEP_SPD   = 32'h0000_1388; // 50.00
	localparam logic [31:0] MIN_POS_SPD     = 32'h0000_000A; // 0.1 r/min
	localparam logic [31:0] MIN_HOME_SPD    = 32'h0000_0001; // 0.01 r/min
	localparam logic [31:0] MAX_SPD         = 32'h0000_C350; // Max rotation speed
	// Amounts in unit amounts
	localparam logic [31:0] RST_REV_AMT     = 32'h0000_0000;
	localparam logic [31:0] RST_SHIFT_AMT   = 32'h0000_03E8; // 1000
	localparam logic [31:0] RST_HOME_COORD  = 32'h0000_0000;
	localparam logic [31:0] RST_DET_RANGE   = 32'h0000_0000;
	localparam logic [31:0] MAX_AMT         = 32'h7735_9400; // 2000000000
	localparam logic [31:0] MIN_COORD       = 32'h88CA_6C00; // -2000000000
	// Times and torque
	localparam logic [31:0] RST_OT_DECEL    = 32'h0000_03E8; // 100.0 ms, 0.1 ms units
	localparam logic [31:0] MAX_OT_DECEL    = 32'h000F_423F; // 99999.9 ms
	localparam logic [31:0] RST_STOP_TIME   = 32'h0000_0000;
	localparam logic [31:0] MAX_STOP_TIME   = 32'h0000_2710; // 10000 ms
	localparam logic [31:0] RST_STOP_TRQ    = 32'h0000_0000;
	localparam logic [31:0] MAX_STOP_TRQ    = 32'h0000_0064; // 100 %

	// Mode configuration field positions
	localparam int F_START_DIR   = 0;  // 2 bits
	localparam int F_AFTER_DIR   = 2;  // 1 bit
	localparam int F_SHIFT_REF   = 4;  // 3 bits
	localparam int F_DECEL_REF   = 8;  // 2 bits
	localparam int F_LS_EDGE     = 12; // 1 bit
	localparam int F_CREEP_REV   = 13; // 1 bit
	localparam int F_OT_ACTION   = 14; // 1 bit
	localparam logic [15:0] RST_MODE_CFG = 16'h0010; // Shift reference = Z-phase

	// Status bit positions
	localparam int S_HOME_POS = 0;
	localparam int S_LS_EVENT = 1;
	localparam int S_DONE     = 2;

	// Homing start direction encoding
	typedef enum logic [1:0] {
		HSS_DIR_FWD  = 2'b00,
		HSS_DIR_REV  = 2'b01,
		HSS_DIR_COND = 2'b10
	} hss_dir_t;

	// Shift reference encoding
	typedef enum logic [2:0] {
		HSS_REF_LS   = 3'b000,
		HSS_REF_Z    = 3'b001,
		HSS_REF_POT  = 3'b010,
		HSS_REF_NOT  = 3'b011,
		HSS_REF_INT  = 3'b100,
		HSS_REF_STOP = 3'b101
	} hss_ref_t;

	// Power-change (latched) configuration
	typedef struct packed {
		logic       ot_stop;      // 0 reverse, 1 stop and cancel
		logic       creep_rev;    // Creep-speed reverse enable
		logic       ls_trailing;  // 0 rising, 1 trailing edge
		logic [1:0] decel_ref;    // 0 LS, 1 +OT, 2 -OT
		hss_ref_t   shift_ref;    // Shift reference
		logic       after_rev;    // Direction after reference
		hss_dir_t   start_dir;    // Start direction
	} hss_pwr_cfg_t;

	// Wishbone request carrier
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [7:0]  adr;
		logic [31:0] dat;
	} hss_wb_req_t;

	// Wishbone answer carrier
	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} hss_wb_rsp_t;

endpackage

// ===== src/hss_top.sv
/*
 * Homing and speed select: settings store, positioning speed selection,
 * home-limit edge detect, homing completion coordinate load and home
 * position output.
 * Assumes a classic Wishbone master, synchronous inputs on clk_sys and
 * a homing sequencer outside that reports completion and position moves.
 */
// The register addresses and the Wishbone register port were chosen for this implementation.
// Summary of operation
// - Select inputs pick one of four speed slots
// - Slots apply only on speed-command variant with selects
// - Slot ranges clamped; defaults 10,50,100,500 r/min
// - Homing travel speed defaults 500 r/min, always writable
// - Creep speed after deceleration reference, default 50
// - Start direction 0 fwd,1 rev,2 judged; power-change
// - Forward raises position count, reverse lowers it
// - Shift reference 0..5, default Z-phase, power-change
// - Deceleration reference 0..2 for Z-phase shift
// - Range zero keeps home output on after homing
// - Overtravel deceleration time 0 to 99999.9 ms
// - Stopper time to 10000 ms, torque to 100%
// - Overtravel: reverse or stop and cancel, power-change
// - Home switch rising or trailing edge, power-change
// - Reverse travel amount 0 to 2000000000
// - Shift distance stored, default 1000, always writable
// - Completion coordinate within plus/minus 2000000000
// - Start direction may oppose post-reference direction
// - Creep deceleration reverse selectable, power-change
// - Power-change settings latch only at power-up
// - Normal completion loads position with coordinate
`timescale 1ns/1ps

module hss_top (
	// Clock, reset, enable
	input  wire logic                clk_sys,
	input  wire logic                srst,
	input  wire logic                clk_en,
	// Wishbone slave
	input  wire hss_pkg::hss_wb_req_t wb_req,
	output hss_pkg::hss_wb_rsp_t     wb_rsp,
	// Host select inputs
	input  wire logic                speed_select_bit0,
	input  wire logic                speed_select_bit1,
	input  wire logic                speed_command_variant,
	input  wire logic                select_by_inputs,
	// Field signals
	input  wire logic                home_limit_switch,
	// Homing sequencer reports
	input  wire logic                homing_done,
	input  wire logic                homing_start,
	input  wire logic                pos_step,
	input  wire logic                pos_dir_fwd,
	// Outputs
	output logic [31:0]              active_speed,
	output logic                     home_position,
	output logic                     home_ls_event,
	output logic [31:0]              current_position,
	output hss_pkg::hss_pwr_cfg_t    active_cfg
);
	import hss_pkg::*;

	// Always-changeable settings, index order 0..12; entry 13 held at zero
	localparam int NREG = 14;
	logic [31:0]  set_q [NREG];      // Setting words
	logic [15:0]  mode_cfg_q;        // Stored power-change fields
	hss_pwr_cfg_t pwr_q;             // Fields in force since power-up
	logic         cfg_loaded_q;      // Power-up latch done
	logic         ls_prev_q;         // Home switch last sample
	logic         ack_q;             // Bus answer
	logic [31:0]  rdat_q;            // Bus read data
	logic [31:0]  speed_q;           // Active speed output
	logic         home_q;            // Home position output
	logic         ls_evt_q;          // Home switch edge pulse
	logic         done_q;            // Homing completed normally
	logic [31:0]  pos_q;             // Current position
	logic [31:0]  anchor_q;          // Position at completion

	// Index ranges and clamps for each setting
	function automatic logic [31:0] clamp_val(input int idx, input logic [31:0] v);
		logic [31:0] r;
		r = v;
		unique case (idx)
			0, 1, 2, 3: begin
				if (v < MIN_POS_SPD) r = MIN_POS_SPD;
				else if (v > MAX_SPD) r = MAX_SPD;
			end
			4, 5: begin
				if (v < MIN_HOME_SPD) r = MIN_HOME_SPD;
				else if (v > MAX_SPD) r = MAX_SPD;
			end
			6, 7: begin
				if (v > MAX_AMT) r = MAX_AMT;
			end
			8: begin
				if ($signed(v) > $signed(MAX_AMT)) r = MAX_AMT;
				else if ($signed(v) < $signed(MIN_COORD)) r = MIN_COORD;
			end
			9: begin
				if (v > MAX_AMT) r = MAX_AMT;
			end
			10: begin
				if (v > MAX_OT_DECEL) r = MAX_OT_DECEL;
			end
			11: begin
				if (v > MAX_STOP_TIME) r = MAX_STOP_TIME;
			end
			12: begin
				if (v > MAX_STOP_TRQ) r = MAX_STOP_TRQ;
			end
			default: r = v;
		endcase
		return r;
	endfunction

	// Byte offset of setting word by index
	function automatic logic [7:0] ofs_of(input int idx);
		logic [7:0] o;
		o = 8'h00;
		unique case (idx)
			0: o = OFS_POS_SPD1;
			1: o = OFS_POS_SPD2;
			2: o = OFS_POS_SPD3;
			3: o = OFS_POS_SPD4;
			4: o = OFS_HOME_SPD;
			5: o = OFS_CREEP_SPD;
			6: o = OFS_REV_AMT;
			7: o = OFS_SHIFT_AMT;
			8: o = OFS_HOME_COORD;
			9: o = OFS_DET_RANGE;
			10: o = OFS_OT_DECEL;
			11: o = OFS_STOP_TIME;
			12: o = OFS_STOP_TRQ;
			default: o = 8'hFF;
		endcase
		return o;
	endfunction

	// Reset value of setting word by index
	function automatic logic [31:0] rst_of(input int idx);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (idx)
			0: v = RST_POS_SPD1;
			1: v = RST_POS_SPD2;
			2: v = RST_POS_SPD3;
			3: v = RST_POS_SPD4;
			4: v = RST_HOME_SPD;
			5: v = RST_CREEP_SPD;
			6: v = RST_REV_AMT;
			7: v = RST_SHIFT_AMT;
			8: v = RST_HOME_COORD;
			9: v = RST_DET_RANGE;
			10: v = RST_OT_DECEL;
			11: v = RST_STOP_TIME;
			12: v = RST_STOP_TRQ;
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	// Bus decode: request taken when idle answer
	wire        bus_req  = wb_req.cyc & wb_req.stb & ~ack_q;
	wire        bus_wr   = bus_req & wb_req.we;
	wire [31:0] sel_mask = {{8{wb_req.sel[3]}}, {8{wb_req.sel[2]}},
				{8{wb_req.sel[1]}}, {8{wb_req.sel[0]}}};

	// Speed slot chosen by the select inputs
	wire [1:0] slot_idx = {speed_select_bit1, speed_select_bit0};
	wire       slots_on = speed_command_variant & select_by_inputs;

	// Home switch edge per latched polarity
	wire ls_rise = home_limit_switch & ~ls_prev_q;
	wire ls_fall = ~home_limit_switch & ls_prev_q;
	wire ls_edge = pwr_q.ls_trailing ? ls_fall : ls_rise;

	// Distance from the completion point
	wire [31:0] dist_raw = pos_q - anchor_q;
	wire [31:0] dist_abs = dist_raw[31] ? (32'h0000_0000 - dist_raw) : dist_raw;
	wire        in_range = (set_q[9] == 32'h0000_0000) | (dist_abs <= set_q[9]);

	// Mode register write image with field limits kept legal
	wire [15:0] mode_wr  = (mode_cfg_q & ~sel_mask[15:0]) | (wb_req.dat[15:0] & sel_mask[15:0]);
	wire        mode_ok  = (mode_wr[F_START_DIR +: 2] != 2'b11)
			 & (mode_wr[F_SHIFT_REF +: 3] <= 3'b101)
			 & (mode_wr[F_DECEL_REF +: 2] != 2'b11);

	// Read data selection
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		for (int i = 0; i < NREG - 1; i++) begin
			if (wb_req.adr == ofs_of(i)) rd_mux = set_q[i];
		end
		if (wb_req.adr == OFS_MODE_CFG) rd_mux = {16'h0000, mode_cfg_q};
		if (wb_req.adr == OFS_ACT_MODE) rd_mux = {16'h0000, 5'h00, pwr_q};
		if (wb_req.adr == OFS_STATUS) rd_mux = {29'h0, done_q, ls_evt_q, home_q};
		if (wb_req.adr == OFS_CUR_POS) rd_mux = pos_q;
	end

	// Always-changeable settings: written any time, clamped to range
	genvar g;
	generate
		for (g = 0; g < NREG - 1; g++) begin : g_set
			always_ff @(posedge clk_sys) begin
				if (srst) begin
					set_q[g] <= rst_of(g);
				end else if (clk_en && bus_wr && wb_req.adr == ofs_of(g)) begin
					set_q[g] <= clamp_val(g, (set_q[g] & ~sel_mask) | (wb_req.dat & sel_mask));
				end
			end
		end
	endgenerate
	assign set_q[NREG-1] = 32'h0000_0000;

	// Stored power-change fields; illegal codes are ignored
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			mode_cfg_q <= RST_MODE_CFG;
		end else if (clk_en && bus_wr && wb_req.adr == OFS_MODE_CFG && mode_ok) begin
			mode_cfg_q <= mode_wr;
		end
	end

	// Power-change fields take effect once, just after reset release
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cfg_loaded_q <= 1'b0;
			pwr_q        <= '0;
		end else if (clk_en && !cfg_loaded_q) begin
			cfg_loaded_q      <= 1'b1;
			pwr_q.start_dir   <= hss_dir_t'(mode_cfg_q[F_START_DIR +: 2]);
			pwr_q.after_rev   <= mode_cfg_q[F_AFTER_DIR];
			pwr_q.shift_ref   <= hss_ref_t'(mode_cfg_q[F_SHIFT_REF +: 3]);
			pwr_q.decel_ref   <= mode_cfg_q[F_DECEL_REF +: 2];
			pwr_q.ls_trailing <= mode_cfg_q[F_LS_EDGE];
			pwr_q.creep_rev   <= mode_cfg_q[F_CREEP_REV];
			pwr_q.ot_stop     <= mode_cfg_q[F_OT_ACTION];
		end
	end

	// Bus answer: one cycle after the request, dropped the next cycle
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else if (clk_en) begin
			ack_q  <= bus_req;
			rdat_q <= bus_req ? rd_mux : 32'h0000_0000;
		end
	end

	// Active speed: slot when selectable, else homing speed
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			speed_q <= RST_POS_SPD1;
		end else if (clk_en) begin
			speed_q <= slots_on ? set_q[slot_idx] : set_q[4];
		end
	end

	// Home switch sampling and edge pulse
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ls_prev_q <= 1'b0;
			ls_evt_q  <= 1'b0;
		end else if (clk_en) begin
			ls_prev_q <= home_limit_switch;
			ls_evt_q  <= ls_edge;
		end
	end

	// Position count; completion loads the configured coordinate
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pos_q    <= 32'h0000_0000;
			anchor_q <= 32'h0000_0000;
		end else if (clk_en) begin
			if (homing_done) begin
				pos_q    <= set_q[8];
				anchor_q <= set_q[8];
			end else if (pos_step) begin
				pos_q <= pos_dir_fwd ? pos_q + 32'h0000_0001 : pos_q - 32'h0000_0001;
			end
		end
	end

	// Completion flag and home position output
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			done_q <= 1'b0;
			home_q <= 1'b0;
		end else if (clk_en) begin
			if (homing_done) done_q <= 1'b1;
			else if (homing_start) done_q <= 1'b0;
			home_q <= (done_q | homing_done) & (homing_done | in_range);
		end
	end

	// Output drive
	assign wb_rsp.ack       = ack_q;
	assign wb_rsp.dat       = rdat_q;
	assign active_speed     = speed_q;
	assign home_position    = home_q;
	assign home_ls_event    = ls_evt_q;
	assign current_position = pos_q;
	assign active_cfg       = pwr_q;

	// Checks
	slot_pick_a: assert property (@(posedge clk_sys) disable iff (srst)
		clk_en && slots_on |=> speed_q == $past(set_q[slot_idx]))
		else $error("speed slot mismatch");
	coord_load_a: assert property (@(posedge clk_sys) disable iff (srst)
		clk_en && homing_done |=> pos_q == $past(set_q[8]))
		else $error("completion coordinate not loaded");
	home_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
		clk_en && done_q && !homing_start && set_q[9] == 32'h0 |=> home_q)
		else $error("home output dropped");
	pwr_stable_a: assert property (@(posedge clk_sys) disable iff (srst)
		cfg_loaded_q |=> $stable(pwr_q))
		else $error("power-change field moved");
	fwd_count_a: assert property (@(posedge clk_sys) disable iff (srst)
		clk_en && pos_step && pos_dir_fwd && !homing_done |=> pos_q == $past(pos_q) + 32'h1)
		else $error("forward count wrong");
	slot_range_a: assert property (@(posedge clk_sys) disable iff (srst)
		set_q[0] >= MIN_POS_SPD && set_q[3] <= MAX_SPD)
		else $error("slot out of range");
	trq_range_a: assert property (@(posedge clk_sys) disable iff (srst)
		set_q[12] <= MAX_STOP_TRQ && set_q[11] <= MAX_STOP_TIME)
		else $error("stopper limit out of range");
	shift_code_a: assert property (@(posedge clk_sys) disable iff (srst)
		mode_cfg_q[F_SHIFT_REF +: 3] <= 3'b101 && mode_cfg_q[F_START_DIR +: 2] != 2'b11)
		else $error("illegal mode code stored");
	ls_edge_a: assert property (@(posedge clk_sys) disable iff (srst)
		clk_en && !pwr_q.ls_trailing && home_limit_switch && !ls_prev_q |=> ls_evt_q)
		else $error("home switch edge missed");
	ack_drop_a: assert property (@(posedge clk_sys) disable iff (srst)
		clk_en && ack_q |=> !ack_q)
		else $error("ack held");
	slot4_c: cover property (@(posedge clk_sys) slots_on && slot_idx == 2'b11);
	done_c: cover property (@(posedge clk_sys) homing_done);
	trail_c: cover property (@(posedge clk_sys) pwr_q.ls_trailing && ls_evt_q);

endmodule

// ===== sim/hss_field_model.sv
/*
 * Field and sequencer model: home limit switch, position moves and
 * homing start and completion reports seen by the settings block.
 * Assumes the bench calls its tasks and that all lines move on clk_sys.
 */
`timescale 1ns/1ps

module hss_field_model (
	// Clock
	input  wire logic clk_sys,
	// Field and sequencer lines
	output logic      home_limit_switch,
	output logic      homing_done,
	output logic      homing_start,
	output logic      pos_step,
	output logic      pos_dir_fwd
);
	// Quiet field at time zero
	initial begin
		home_limit_switch = 1'b0;
		homing_done = 1'b0;
		homing_start = 1'b0;
		pos_step = 1'b0;
		pos_dir_fwd = 1'b0;
	end

	// Moves n units; direction line inverts once idle
	task automatic step(input int n, input logic fwd);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_sys);
			pos_step <= 1'b1;
			pos_dir_fwd <= fwd;
		end
		@(posedge clk_sys);
		pos_step <= 1'b0;
		pos_dir_fwd <= ~fwd;
	endtask

	// Moves the home limit switch to a new level
	task automatic sw(input logic v);
		@(posedge clk_sys);
		home_limit_switch <= v;
	endtask

	// Starts a homing run and reports normal completion
	task automatic finish();
		@(posedge clk_sys);
		homing_start <= 1'b1;
		@(posedge clk_sys);
		homing_start <= 1'b0;
		repeat (3) @(posedge clk_sys);
		homing_done <= 1'b1;
		@(posedge clk_sys);
		homing_done <= 1'b0;
	endtask
endmodule

// ===== sim/testbench.sv
/*
 * Self-checking bench for hss_top: Wishbone reads and writes, speed
 * selection, power-change settings, switch edge and homing completion.
 * Assumes hss_field_model drives the field and sequencer inputs.
 */
`timescale 1ns/1ps

module testbench;
	import hss_pkg::*;

	// Clock, reset and bus
	logic        clk_sys = 1'b0;
	logic        srst = 1'b1;
	logic        clk_en = 1'b1;
	hss_wb_req_t wb_req = '0;
	hss_wb_rsp_t wb_rsp;
	// Host selects
	logic        speed_select_bit0 = 1'b0;
	logic        speed_select_bit1 = 1'b0;
	logic        speed_command_variant = 1'b0;
	logic        select_by_inputs = 1'b0;
	// Field lines and outputs
	logic        home_limit_switch, homing_done, homing_start, pos_step, pos_dir_fwd;
	logic [31:0] active_speed, current_position;
	logic        home_position, home_ls_event;
	hss_pwr_cfg_t active_cfg;
	// Counters and scratch
	int          n_fail = 0;
	int          comparisons = 0;
	int          c;
	logic [31:0] q;

	// Stored settings and their reset values
	localparam logic [7:0] RA [14] = '{OFS_POS_SPD1, OFS_POS_SPD2, OFS_POS_SPD3,
		OFS_POS_SPD4, OFS_HOME_SPD, OFS_CREEP_SPD, OFS_MODE_CFG, OFS_REV_AMT,
		OFS_SHIFT_AMT, OFS_HOME_COORD, OFS_DET_RANGE, OFS_OT_DECEL, OFS_STOP_TIME,
		OFS_STOP_TRQ};
	localparam logic [31:0] RV [14] = '{RST_POS_SPD1, RST_POS_SPD2, RST_POS_SPD3,
		RST_POS_SPD4, RST_HOME_SPD, RST_CREEP_SPD, {16'h0000, RST_MODE_CFG},
		RST_REV_AMT, RST_SHIFT_AMT, RST_HOME_COORD, RST_DET_RANGE, RST_OT_DECEL,
		RST_STOP_TIME, RST_STOP_TRQ};
	// Out-of-range writes and their clamped values
	localparam logic [7:0] CA [7] = '{OFS_POS_SPD1, OFS_POS_SPD4, OFS_HOME_SPD,
		OFS_OT_DECEL, OFS_STOP_TIME, OFS_STOP_TRQ, OFS_REV_AMT};
	localparam logic [31:0] CW [7] = '{32'h0, 32'h0001_0000, 32'h0, 32'h00FF_FFFF,
		32'h0000_FFFF, 32'h0000_0065, 32'h7FFF_FFFF};
	localparam logic [31:0] CE [7] = '{MIN_POS_SPD, MAX_SPD, MIN_HOME_SPD,
		MAX_OT_DECEL, MAX_STOP_TIME, MAX_STOP_TRQ, MAX_AMT};
	// Mode words with a reserved code in one field
	localparam logic [31:0] BAD [3] = '{32'h0000_0003, 32'h0000_0060, 32'h0000_0300};

	// 50 MHz clock
	always #10 clk_sys = ~clk_sys;

	hss_top hss_top_inst (.clk_sys, .srst, .clk_en, .wb_req, .wb_rsp,
		.speed_select_bit0, .speed_select_bit1, .speed_command_variant,
		.select_by_inputs, .home_limit_switch, .homing_done, .homing_start,
		.pos_step, .pos_dir_fwd, .active_speed, .home_position, .home_ls_event,
		.current_position, .active_cfg);

	hss_field_model hss_field_model_inst (.clk_sys, .home_limit_switch,
		.homing_done, .homing_start, .pos_step, .pos_dir_fwd);

	// Counts and reports one comparison
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One classic cycle; request held until ack is seen high
	task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: a, dat: d};
		// Ack and read data are looked at on the rising edge only
		do begin
			@(posedge clk_sys);
			n++;
		end while (wb_rsp.ack !== 1'b1 && n < 40);
		if (n >= 40) begin
			n_fail++;
			$display("ERROR bus ack expected 1 seen %b", wb_rsp.ack);
			give_verdict();
		end
		q = wb_rsp.dat;
		wb_req <= '0;
	endtask

	// Read and compare
	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(what, exp, q);
	endtask

	// Counts switch event pulses over six cycles
	task automatic ev_count();
		c = 0;
		repeat (6) begin
			@(negedge clk_sys);
			if (home_ls_event === 1'b1) begin
				c++;
			end
		end
	endtask

	// Prints the counts and the verdict, then stops
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Watchdog against a hung handshake
	initial begin
		#400000;
		n_fail++;
		give_verdict();
	end

	// Main sequence
	initial begin
		repeat (2) @(posedge clk_sys);
		srst <= 1'b0;
		for (int i = 0; i < 14; i++) begin
			rdc("reset value", RA[i], RV[i]);
		end
		rdc("unmapped", 8'h44, 32'h0);
		chk("active_cfg", 32'h0000_0008, {21'h0, active_cfg});
		$display("TEST reset values done");

		@(posedge clk_sys);
		speed_command_variant <= 1'b1;
		select_by_inputs <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			{speed_select_bit1, speed_select_bit0} <= i[1:0];
			repeat (2) @(negedge clk_sys);
			chk("active_speed", RV[i], active_speed);
		end
		@(posedge clk_sys);
		speed_command_variant <= 1'b0;
		repeat (2) @(negedge clk_sys);
		chk("speed off variant", RST_HOME_SPD, active_speed);
		@(posedge clk_sys);
		speed_command_variant <= 1'b1;
		select_by_inputs <= 1'b0;
		repeat (2) @(negedge clk_sys);
		chk("speed no select", RST_HOME_SPD, active_speed);
		$display("TEST speed select done");

		for (int i = 0; i < 7; i++) begin
			xfer(1'b1, CA[i], CW[i]);
			rdc("clamped", CA[i], CE[i]);
		end
		xfer(1'b1, OFS_POS_SPD2, 32'h0000_1234);
		@(posedge clk_sys);
		select_by_inputs <= 1'b1;
		{speed_select_bit1, speed_select_bit0} <= 2'b01;
		repeat (2) @(negedge clk_sys);
		chk("new slot speed", 32'h0000_1234, active_speed);
		$display("TEST ranges done");

		xfer(1'b1, OFS_MODE_CFG, 32'h0000_7256);
		rdc("mode", OFS_MODE_CFG, 32'h0000_7256);
		chk("cfg held", 32'h0000_0008, {21'h0, active_cfg});
		for (int i = 0; i < 3; i++) begin
			xfer(1'b1, OFS_MODE_CFG, BAD[i]);
			rdc("mode kept", OFS_MODE_CFG, 32'h0000_7256);
		end
		$display("TEST mode done");

		hss_field_model_inst.sw(1'b1);
		ev_count();
		chk("switch rise", 32'd1, c);
		hss_field_model_inst.sw(1'b0);
		ev_count();
		chk("switch fall", 32'd0, c);
		$display("TEST switch edge done");

		xfer(1'b1, OFS_HOME_COORD, MIN_COORD);
		hss_field_model_inst.finish();
		@(negedge clk_sys);
		chk("position loaded", MIN_COORD, current_position);
		chk("home output", 32'd1, {31'h0, home_position});
		hss_field_model_inst.step(3, 1'b1);
		hss_field_model_inst.step(1, 1'b0);
		@(negedge clk_sys);
		chk("position moved", MIN_COORD + 32'd2, current_position);
		chk("home kept", 32'd1, {31'h0, home_position});
		xfer(1'b1, OFS_CUR_POS, 32'h0);
		rdc("position reg", OFS_CUR_POS, MIN_COORD + 32'd2);
		rdc("status", OFS_STATUS, 32'h0000_0005);
		xfer(1'b1, OFS_DET_RANGE, 32'd1);
		repeat (2) @(negedge clk_sys);
		chk("home out of range", 32'd0, {31'h0, home_position});
		xfer(1'b1, OFS_DET_RANGE, 32'd2);
		repeat (2) @(negedge clk_sys);
		chk("home in range", 32'd1, {31'h0, home_position});
		$display("TEST homing done");
		give_verdict();
	end
endmodule
